// ---- hw/reset_seq_cfg.svh ----
// Constants of the reset configuration sequencer: timing counts and search ranges.
// Assumes a 200 MHz core clock and a sequence that starts at master reset release.
// How it works
// - Found update loads, applies, restarts sequence
// - Latched GPIO picks OTP config, EEPROM searched after it when enabled
// - Report OTP load error or loaded number
// - OTP writes only listed registers in image
// - Feedback divider set starts parallel PLL calibration
// - Reconfigure slave port protocols as OTP writes land
// - EEPROM block applied only when checksum passes
// - Search all addresses until block applied
// - Hotfix copied and run after EEPROM search
// - Recalibrate PLL when any configuration loaded
// - Completion enables ports, image, outputs, monitors, alarms
// - Complete with defaults; expose failure status bits
// - Capture GPIO levels at reset release
// - Try addresses 1010000-1010111 at three rates
// - Check blocks at offsets 0x0000 and 0xF000
// - Build default register image before loading
`ifndef RESET_SEQ_CFG_SVH
`define RESET_SEQ_CFG_SVH
`define CLK_MHZ 200
`define EE_ADDR_FIRST 7'h50
`define EE_ADDR_LAST 7'h57
`define EE_OFS_LOW 16'h0000
`define EE_OFS_HIGH 16'hF000
`define IMAGE_DEPTH 256
`define IMAGE_AW 8
`define WAIT_NO_EE_MS 15
`define WAIT_NO_ANSWER_MS 150
`define WAIT_FACTOR_NUM 115
`define WAIT_FACTOR_DEN 100
`define WAIT_PER_256 2342
`define WAIT_FIXED 2250
// Register image addresses that steer the sequence
`define IMG_APLL_FB 8'h10
`define IMG_SER0_PROTO 8'h20
`define IMG_SER1_PROTO 8'h21
`endif

// ---- hw/reset_seq_pkg.sv ----
// Types shared by the reset configuration sequencer files.
// Assumes the constants header is compiled alongside.
package reset_seq_pkg;
  typedef enum logic [1:0] {RATE_1M, RATE_400K, RATE_100K} ee_rate_e;
  typedef struct packed {
    logic otp_missing;
    logic otp_bad_sum;
    logic ee_none;
    logic ee_bad_block;
    logic ee_no_config;
  } fail_s;
  typedef struct packed {
    logic ports_en;
    logic image_applied;
    logic outputs_en;
    logic monitors_en;
    logic alarms_en;
  } enable_s;
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } img_wr_s;
endpackage

// ---- hw/image_ram.sv ----
// Register image memory: one write port, registered read data.
// Assumes writes and reads arrive from the sequencer's single clock.
`timescale 1ns/1ps
`include "reset_seq_cfg.svh"
module image_ram
  import reset_seq_pkg::*;
(
  input wire logic clk_in, // Core clock
  input wire img_wr_s wr_in, // Write request
  input wire logic [7:0] rd_addr_in, // Read address
  output logic [7:0] rd_data_out // Read data, one cycle later
);
  logic [7:0] mem [0:`IMAGE_DEPTH-1];
  logic [7:0] rd_data_r;
  always_ff @(posedge clk_in) begin
    if (wr_in.we) begin
      mem[wr_in.addr] <= wr_in.data;
    end
    rd_data_r <= mem[rd_addr_in];
  end
  assign rd_data_out = rd_data_r;
endmodule

// ---- hw/reset_config_load_sequencer.sv ----
// Reset configuration load sequencer: OTP and EEPROM loading, hotfix, completion.
// Assumes OTP and EEPROM engines answer with single-cycle done pulses on this clock.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "reset_seq_cfg.svh"
module reset_config_load_sequencer
  import reset_seq_pkg::*;
(
  input wire logic clk_in, // Core clock 200 MHz
  input wire logic rst_b_in, // Async master reset, low
  input wire logic [3:0] gpio_pins_in, // GPIO pins, asynchronous
  input wire logic update_scan_en_in, // Update scanning enabled
  input wire logic ee_search_en_in, // EEPROM search enabled
  output logic ee_req_out, // Probe or read request to EEPROM engine
  output logic [6:0] ee_dev_addr_out, // EEPROM bus address
  output ee_rate_e ee_rate_out, // Master bus rate
  output logic [15:0] ee_offset_out, // Block offset inside EEPROM
  output logic ee_want_update_out, // Request is for update block
  input wire logic ee_done_in, // Engine finished request, pulse
  input wire logic ee_ack_in, // Device answered
  input wire logic ee_found_in, // Header of wanted kind found
  input wire logic ee_sum_ok_in, // Checksum passed
  input wire img_wr_s ee_wr_in, // Image write from EEPROM stream
  output logic otp_req_out, // OTP config lookup request
  output logic [3:0] otp_cfg_num_out, // Requested configuration number
  input wire logic otp_done_in, // OTP lookup finished, pulse
  input wire logic otp_found_in, // Config present
  input wire logic otp_sum_ok_in, // Config checksum passed
  input wire img_wr_s otp_wr_in, // Image write from OTP stream
  input wire logic hotfix_present_in, // OTP holds a hotfix
  output logic hotfix_run_out, // Hotfix copy and run request
  input wire logic hotfix_done_in, // Hotfix finished, pulse
  output logic update_apply_out, // Apply loaded functional update
  output logic apll_cal_out, // Start PLL calibration, pulse
  output logic apll_lock_xtal_out, // Lock PLL to crystal_ref_input
  input wire logic apll_locked_in, // PLL calibrated and locked
  output logic [1:0] port_proto_out, // Slave port protocol, 1 is SPI
  output enable_s enables_out, // Completion enables
  output logic seq_done_out, // Sequence finished
  output fail_s fail_out, // Failure status bits
  output logic otp_loaded_out, // OTP configuration applied
  output logic [3:0] otp_loaded_num_out, // Applied configuration number
  input wire logic [7:0] img_rd_addr_in, // Image read address
  output logic [7:0] img_rd_data_out // Image read data
);
  // ************************************************************
  // Sequencer state
  // ************************************************************
  typedef enum logic [3:0] {
    S_CLEAR, S_UPD_SCAN, S_UPD_WAIT, S_OTP, S_OTP_WAIT, S_PROTO,
    S_EE_REQ, S_EE_WAIT, S_HOTFIX, S_HF_WAIT, S_CAL, S_CAL_WAIT,
    S_EN_PORTS, S_EN_IMAGE, S_EN_MON, S_DONE
  } seq_e;

  function automatic logic last_addr(input logic [6:0] a);
    last_addr = (a == `EE_ADDR_LAST);
  endfunction

  seq_e state_r, state_nxt;
  logic [3:0] gpio_s1_r, gpio_s2_r, gpio_lat_r, gpio_lat_nxt;
  logic latched_r, latched_nxt;
  logic [6:0] addr_r, addr_nxt;
  ee_rate_e rate_r, rate_nxt;
  logic ofs_hi_r, ofs_hi_nxt;
  logic update_phase_r, update_phase_nxt;
  logic any_ack_r, any_ack_nxt;
  logic cfg_loaded_r, cfg_loaded_nxt;
  logic fb_written_r, fb_written_nxt;
  logic [7:0] clr_addr_r, clr_addr_nxt;
  logic [1:0] proto_r, proto_nxt;
  fail_s fail_r, fail_nxt;
  enable_s en_r, en_nxt;
  logic otp_loaded_r, otp_loaded_nxt;
  logic [3:0] otp_num_r, otp_num_nxt;
  logic apll_cal_r, apll_cal_nxt;
  logic lock_r, lock_nxt;
  img_wr_s wr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;

  // ************************************************************
  // GPIO capture
  // ************************************************************
  // No reset, so the held pin levels are through both stages at release
  always_ff @(posedge clk_in) begin
    gpio_s1_r <= gpio_pins_in;
    gpio_s2_r <= gpio_s1_r;
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    gpio_lat_nxt = gpio_lat_r;
    latched_nxt = latched_r;
    addr_nxt = addr_r;
    rate_nxt = rate_r;
    ofs_hi_nxt = ofs_hi_r;
    update_phase_nxt = update_phase_r;
    any_ack_nxt = any_ack_r;
    cfg_loaded_nxt = cfg_loaded_r;
    fb_written_nxt = fb_written_r;
    clr_addr_nxt = clr_addr_r;
    proto_nxt = proto_r;
    fail_nxt = fail_r;
    en_nxt = en_r;
    otp_loaded_nxt = otp_loaded_r;
    otp_num_nxt = otp_num_r;
    apll_cal_nxt = 1'b0;
    lock_nxt = lock_r;
    wr = '0;
    // Caught once, first clock after release, so it never reads a port at reset
    if (!latched_r) begin
      gpio_lat_nxt = gpio_s2_r;
      latched_nxt = 1'b1;
    end
    unique case (state_r)
      S_CLEAR: begin
        wr.we = 1'b1;
        wr.addr = clr_addr_r;
        wr.data = 8'h00;
        clr_addr_nxt = clr_addr_r + 8'h01;
        if (clr_addr_r == 8'hFF) begin
          state_nxt = (update_scan_en_in && ee_search_en_in) ? S_UPD_SCAN : S_OTP;
          addr_nxt = `EE_ADDR_FIRST;
          rate_nxt = RATE_1M;
          update_phase_nxt = 1'b1;
          any_ack_nxt = 1'b0;
        end
      end
      S_UPD_SCAN: state_nxt = S_UPD_WAIT;
      S_UPD_WAIT: begin
        if (ee_done_in) begin
          if (ee_ack_in) begin
            any_ack_nxt = 1'b1;
          end
          if (ee_ack_in && ee_found_in && ee_sum_ok_in) begin
            // Restart from the top keeps all sequence state honest
            state_nxt = S_CLEAR;
            clr_addr_nxt = 8'h00;
          end else if (!last_addr(addr_r)) begin
            addr_nxt = addr_r + 7'h01;
            state_nxt = S_UPD_SCAN;
          end else begin
            state_nxt = S_OTP;
          end
        end
      end
      S_OTP: state_nxt = S_OTP_WAIT;
      S_OTP_WAIT: begin
        if (otp_wr_in.we) begin
          wr = otp_wr_in;
          if (otp_wr_in.addr == `IMG_APLL_FB) begin
            fb_written_nxt = 1'b1;
          end
          if (otp_wr_in.addr == `IMG_SER0_PROTO) begin
            proto_nxt[0] = otp_wr_in.data[0];
          end
          if (otp_wr_in.addr == `IMG_SER1_PROTO) begin
            proto_nxt[1] = otp_wr_in.data[0];
          end
        end
        if (otp_done_in) begin
          if (otp_found_in && otp_sum_ok_in) begin
            otp_loaded_nxt = 1'b1;
            otp_num_nxt = gpio_lat_r;
            cfg_loaded_nxt = 1'b1;
            state_nxt = S_PROTO;
          end else begin
            fail_nxt.otp_missing = !otp_found_in;
            fail_nxt.otp_bad_sum = otp_found_in;
            state_nxt = S_PROTO;
          end
        end
      end
      S_PROTO: begin
        apll_cal_nxt = fb_written_r;
        state_nxt = ee_search_en_in ? S_EE_REQ : S_HOTFIX;
        addr_nxt = `EE_ADDR_FIRST;
        rate_nxt = RATE_1M;
        ofs_hi_nxt = 1'b0;
        update_phase_nxt = 1'b0;
        any_ack_nxt = 1'b0;
      end
      S_EE_REQ: state_nxt = S_EE_WAIT;
      S_EE_WAIT: begin
        if (ee_wr_in.we && ee_sum_ok_in) begin
          wr = ee_wr_in;
        end
        if (ee_done_in) begin
          state_nxt = S_EE_REQ;
          if (ee_ack_in) begin
            any_ack_nxt = 1'b1;
          end
          if (ee_ack_in && ee_found_in && ee_sum_ok_in) begin
            cfg_loaded_nxt = 1'b1;
            state_nxt = S_HOTFIX;
          end else if (ee_ack_in && !ofs_hi_r) begin
            if (ee_found_in) begin
              fail_nxt.ee_bad_block = 1'b1;
            end
            ofs_hi_nxt = 1'b1;
          end else begin
            if (ee_ack_in && ee_found_in) begin
              fail_nxt.ee_bad_block = 1'b1;
            end
            ofs_hi_nxt = 1'b0;
            if (!last_addr(addr_r)) begin
              addr_nxt = addr_r + 7'h01;
            end else if (!any_ack_r && !ee_ack_in && rate_r != RATE_100K) begin
              addr_nxt = `EE_ADDR_FIRST;
              rate_nxt = (rate_r == RATE_1M) ? RATE_400K : RATE_100K;
            end else begin
              fail_nxt.ee_none = !(any_ack_r || ee_ack_in);
              fail_nxt.ee_no_config = 1'b1;
              state_nxt = S_HOTFIX;
            end
          end
        end
      end
      S_HOTFIX: state_nxt = hotfix_present_in ? S_HF_WAIT : S_CAL;
      S_HF_WAIT: begin
        if (hotfix_done_in) begin
          state_nxt = S_CAL;
        end
      end
      S_CAL: begin
        apll_cal_nxt = cfg_loaded_r;
        lock_nxt = cfg_loaded_r;
        state_nxt = cfg_loaded_r ? S_CAL_WAIT : S_EN_PORTS;
      end
      S_CAL_WAIT: begin
        // Lock seen beside the pulse is stale, the PLL has not started yet
        if (apll_locked_in && !apll_cal_r) begin
          state_nxt = S_EN_PORTS;
        end
      end
      S_EN_PORTS: begin
        en_nxt.ports_en = 1'b1;
        state_nxt = S_EN_IMAGE;
      end
      S_EN_IMAGE: begin
        en_nxt.image_applied = 1'b1;
        en_nxt.outputs_en = 1'b1;
        state_nxt = S_EN_MON;
      end
      S_EN_MON: begin
        en_nxt.monitors_en = 1'b1;
        state_nxt = S_DONE;
      end
      S_DONE: en_nxt.alarms_en = 1'b1;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= S_CLEAR;
      gpio_lat_r <= 4'h0;
      latched_r <= 1'b0;
      addr_r <= 7'h00;
      rate_r <= RATE_1M;
      ofs_hi_r <= 1'b0;
      update_phase_r <= 1'b0;
      any_ack_r <= 1'b0;
      cfg_loaded_r <= 1'b0;
      fb_written_r <= 1'b0;
      clr_addr_r <= 8'h00;
      proto_r <= 2'h0;
      fail_r <= '0;
      en_r <= '0;
      otp_loaded_r <= 1'b0;
      otp_num_r <= 4'h0;
      apll_cal_r <= 1'b0;
      lock_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      gpio_lat_r <= gpio_lat_nxt;
      latched_r <= latched_nxt;
      addr_r <= addr_nxt;
      rate_r <= rate_nxt;
      ofs_hi_r <= ofs_hi_nxt;
      update_phase_r <= update_phase_nxt;
      any_ack_r <= any_ack_nxt;
      cfg_loaded_r <= cfg_loaded_nxt;
      fb_written_r <= fb_written_nxt;
      clr_addr_r <= clr_addr_nxt;
      proto_r <= proto_nxt;
      fail_r <= fail_nxt;
      en_r <= en_nxt;
      otp_loaded_r <= otp_loaded_nxt;
      otp_num_r <= otp_num_nxt;
      apll_cal_r <= apll_cal_nxt;
      lock_r <= lock_nxt;
    end
  end

  // ************************************************************
  // Register image and outputs
  // ************************************************************
  assign rd_addr = img_rd_addr_in;
  image_ram u_image (
    .clk_in(clk_in),
    .wr_in(wr),
    .rd_addr_in(rd_addr),
    .rd_data_out(rd_data)
  );
  assign img_rd_data_out = rd_data;

  assign ee_req_out = (state_r == S_EE_REQ) || (state_r == S_UPD_SCAN);
  assign ee_dev_addr_out = addr_r;
  assign ee_rate_out = rate_r;
  assign ee_offset_out = ofs_hi_r ? `EE_OFS_HIGH : `EE_OFS_LOW;
  assign ee_want_update_out = update_phase_r;
  assign otp_req_out = (state_r == S_OTP);
  assign otp_cfg_num_out = gpio_lat_r;
  assign hotfix_run_out = (state_r == S_HF_WAIT);
  assign update_apply_out = (state_r == S_UPD_WAIT) && ee_done_in && ee_ack_in
                            && ee_found_in && ee_sum_ok_in;
  assign apll_cal_out = apll_cal_r;
  assign apll_lock_xtal_out = lock_r;
  assign port_proto_out = proto_r;
  assign enables_out = en_r;
  // Ports stay deaf until the first completion step has run
  assign seq_done_out = en_r.alarms_en;
  assign fail_out = fail_r;
  assign otp_loaded_out = otp_loaded_r;
  assign otp_loaded_num_out = otp_num_r;
endmodule

// ---- tb/reset_seq_properties.sv ----
// Checker for the reset configuration sequencer, bound to its top.
// Assumes one clock domain and the port set of the sequencer.
`timescale 1ns/1ps
module reset_seq_properties
  import reset_seq_pkg::*;
(
  input wire logic clk_in, // Core clock
  input wire logic rst_b_in, // Reset, low
  input wire logic ee_req_out, // EEPROM request
  input wire logic [6:0] ee_dev_addr_out, // EEPROM address
  input wire logic [15:0] ee_offset_out, // Block offset
  input wire logic ee_want_update_out, // Update probe
  input wire logic ee_done_in, // Engine done
  input wire logic ee_found_in, // Block found
  input wire logic ee_sum_ok_in, // Sum passed
  input wire logic otp_req_out, // OTP request
  input wire logic [3:0] otp_cfg_num_out, // Requested number
  input wire logic hotfix_present_in, // Hotfix held
  input wire logic hotfix_run_out, // Hotfix run
  input wire logic update_apply_out, // Update apply
  input wire logic apll_cal_out, // PLL calibration
  input wire logic apll_lock_xtal_out, // PLL lock
  input wire logic apll_locked_in, // PLL locked
  input wire enable_s enables_out, // Completion enables
  input wire logic seq_done_out, // Done
  input wire fail_s fail_out, // Failure bits
  input wire logic otp_loaded_out, // OTP applied
  input wire logic [3:0] otp_loaded_num_out // Applied number
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_tail;
    $rose(enables_out.image_applied) && enables_out.outputs_en
      ##1 $rose(enables_out.monitors_en) ##1 $rose(enables_out.alarms_en);
  endsequence
  property p_completion_order;
    $rose(enables_out.ports_en) |=> s_tail;
  endproperty
  a_completion_order: assert property (p_completion_order) else $error("completion order");
  property p_done_tracks;
    seq_done_out == enables_out.alarms_en;
  endproperty
  a_done_tracks: assert property (p_done_tracks) else $error("done early or late");
  property p_update_cause;
    update_apply_out |-> ee_done_in && ee_want_update_out && ee_found_in && ee_sum_ok_in;
  endproperty
  a_update_cause: assert property (p_update_cause) else $error("update without block");
  property p_probe_range;
    ee_req_out |-> ee_dev_addr_out inside {[7'h50:7'h57]}
      && ee_offset_out inside {16'h0000, 16'hf000};
  endproperty
  a_probe_range: assert property (p_probe_range) else $error("probe out of range");
  property p_otp_num;
    $rose(otp_loaded_out) |-> otp_loaded_num_out == otp_cfg_num_out;
  endproperty
  a_otp_num: assert property (p_otp_num) else $error("wrong loaded number");
  property p_hotfix_gate;
    $rose(hotfix_run_out) |-> hotfix_present_in && !enables_out.ports_en;
  endproperty
  a_hotfix_gate: assert property (p_hotfix_gate) else $error("hotfix misplaced");
  property p_lock_first;
    $rose(enables_out.ports_en) && apll_lock_xtal_out |-> apll_locked_in;
  endproperty
  a_lock_first: assert property (p_lock_first) else $error("ports before lock");
  property p_cal_pulse;
    apll_cal_out |=> !apll_cal_out;
  endproperty
  a_cal_pulse: assert property (p_cal_pulse) else $error("cal pulse too long");
  property p_fail_sticky;
    ($past(fail_out) & ~fail_out) == 5'h00;
  endproperty
  a_fail_sticky: assert property (p_fail_sticky) else $error("status bit lost");
  property p_quiet_after;
    seq_done_out |-> !ee_req_out && !otp_req_out;
  endproperty
  a_quiet_after: assert property (p_quiet_after) else $error("request after done");
endmodule
bind reset_config_load_sequencer reset_seq_properties u_reset_seq_properties (.clk_in,
  .rst_b_in, .ee_req_out, .ee_dev_addr_out, .ee_offset_out, .ee_want_update_out, .ee_done_in,
  .ee_found_in, .ee_sum_ok_in, .otp_req_out, .otp_cfg_num_out, .hotfix_present_in,
  .hotfix_run_out, .update_apply_out, .apll_cal_out, .apll_lock_xtal_out, .apll_locked_in,
  .enables_out, .seq_done_out, .fail_out, .otp_loaded_out, .otp_loaded_num_out);

// ---- tb/far_side_model.sv ----
// Model of the EEPROM engine, OTP store, hotfix runner and system PLL.
// Assumes EEPROM, OTP and calibration requests are single-cycle pulses from the sequencer; hotfix run is a level.
`timescale 1ns/1ps
`include "reset_seq_cfg.svh"
module far_side_model
  import reset_seq_pkg::*;
(
  input wire logic clk_in, // Core clock
  input wire logic rst_b_in, // Reset, low
  input wire logic ee_req_in, // EEPROM request
  input wire logic [6:0] ee_dev_addr_in, // Probed address
  input wire logic [15:0] ee_offset_in, // Block offset
  input wire logic ee_want_update_in, // Update probe
  input wire logic otp_req_in, // OTP request
  input wire logic hotfix_run_in, // Hotfix run
  input wire logic apll_cal_in, // PLL calibration
  input wire logic [6:0] ack_addr_in, // Answering address
  input wire logic [2:0] blk_ok_in, // Sum ok: high, low, update
  input wire logic upd_in, // Update block present
  input wire logic otp_found_cfg_in, // OTP config present
  input wire logic otp_ok_cfg_in, // OTP sum good
  output logic ee_done_out, // Engine done
  output logic ee_ack_out, // Answered
  output logic ee_found_out, // Block found
  output logic ee_sum_ok_out, // Sum passed
  output img_wr_s ee_wr_out, // EEPROM image write
  output logic otp_done_out, // OTP done
  output logic otp_found_out, // OTP found
  output logic otp_sum_ok_out, // OTP sum ok
  output img_wr_s otp_wr_out, // OTP image write
  output logic hotfix_done_out, // Hotfix done
  output logic apll_locked_out // PLL locked
);
  // ****************************************
  // Behaviour
  // ****************************************
  logic [2:0] ee_cnt_r, otp_cnt_r, hf_cnt_r;
  logic [3:0] lk_cnt_r;
  logic [6:0] addr_r;
  logic [15:0] ofs_r;
  logic upd_r, used_r, hf_r, hit, fnd, ok, good;
  assign hit = addr_r == ack_addr_in;
  // Update block answers once, so the restart sees none
  assign fnd = hit && (!upd_r || (upd_in && !used_r));
  assign ok = fnd && (upd_r ? blk_ok_in[0] : blk_ok_in[ofs_r[15] ? 2 : 1]);
  assign good = otp_found_cfg_in && otp_ok_cfg_in;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      {ee_cnt_r, otp_cnt_r, hf_cnt_r, lk_cnt_r, addr_r, ofs_r, upd_r, used_r, hf_r} <= '0;
      {ee_done_out, ee_ack_out, ee_found_out, ee_sum_ok_out, ee_wr_out} <= '0;
      {otp_done_out, otp_found_out, otp_sum_ok_out, otp_wr_out, hotfix_done_out} <= '0;
      apll_locked_out <= 1'b1;
    end else begin
      {ee_done_out, otp_done_out, hotfix_done_out} <= 3'h0;
      ee_wr_out <= '0;
      otp_wr_out <= '0;
      // Answer levels are only meaningful beside done
      {ee_ack_out, ee_found_out, ee_sum_ok_out} <= ~{ee_ack_out, ee_found_out, ee_sum_ok_out};
      {otp_found_out, otp_sum_ok_out} <= ~{otp_found_out, otp_sum_ok_out};
      if (ee_req_in) begin
        {addr_r, ofs_r, upd_r, ee_cnt_r} <= {ee_dev_addr_in, ee_offset_in, ee_want_update_in, 3'h3};
      end else if (ee_cnt_r != 3'h0) begin
        ee_cnt_r <= ee_cnt_r - 3'h1;
        if (ee_cnt_r == 3'h1) begin
          {ee_done_out, ee_ack_out, ee_found_out, ee_sum_ok_out} <= {1'b1, hit, fnd, ok};
          ee_wr_out <= '{fnd, ofs_r[15] ? 8'h31 : 8'h30, 8'ha5};
          used_r <= used_r | (upd_r && ok);
        end
      end
      if (otp_req_in) begin
        otp_cnt_r <= 3'h4;
      end else if (otp_cnt_r != 3'h0) begin
        otp_cnt_r <= otp_cnt_r - 3'h1;
        // Full-byte writes of steering registers
        if (otp_cnt_r == 3'h4 && good) otp_wr_out <= '{1'b1, `IMG_SER1_PROTO, 8'h01};
        if (otp_cnt_r == 3'h3 && good) otp_wr_out <= '{1'b1, `IMG_APLL_FB, 8'h01};
        if (otp_cnt_r == 3'h2 && good) otp_wr_out <= '{1'b1, `IMG_SER0_PROTO, 8'h01};
        if (otp_cnt_r == 3'h1) begin
          {otp_done_out, otp_found_out, otp_sum_ok_out} <= {1'b1, otp_found_cfg_in, otp_ok_cfg_in};
        end
      end
      hf_r <= hotfix_run_in;
      if (hotfix_run_in && !hf_r) hf_cnt_r <= 3'h4;
      else if (hf_cnt_r != 3'h0) hf_cnt_r <= hf_cnt_r - 3'h1;
      if (hf_cnt_r == 3'h1) hotfix_done_out <= 1'b1;
      if (apll_cal_in) {apll_locked_out, lk_cnt_r} <= {1'b0, 4'ha};
      else if (lk_cnt_r != 4'h0) lk_cnt_r <= lk_cnt_r - 4'h1;
      if (lk_cnt_r == 4'h1) apll_locked_out <= 1'b1;
    end
  end
endmodule

// ---- tb/test_reset_config_load_sequencer.sv ----
// Self-checking bench: four reset sequences with OTP, EEPROM and update cases.
// Assumes the far side model answers every engine request.
`timescale 1ns/1ps
`include "reset_seq_cfg.svh"
module test_reset_config_load_sequencer;
  import reset_seq_pkg::*;
  logic clk_in = 1'b0, rst_b_in = 1'b0, update_scan_en_in = 1'b0, ee_search_en_in = 1'b0;
  logic hotfix_present_in = 1'b0, upd = 1'b0, ofound = 1'b0, ook = 1'b0;
  logic [3:0] gpio_pins_in = 4'h0;
  logic [7:0] img_rd_addr_in = 8'h00;
  logic [6:0] ack_addr = 7'h00;
  logic [2:0] blk_ok = 3'h0;
  logic ee_req_out, ee_want_update_out, ee_done_in, ee_ack_in, ee_found_in, ee_sum_ok_in;
  logic otp_req_out, otp_done_in, otp_found_in, otp_sum_ok_in, hotfix_run_out, hotfix_done_in;
  logic update_apply_out, apll_cal_out, apll_lock_xtal_out, apll_locked_in, seq_done_out;
  logic otp_loaded_out;
  logic [6:0] ee_dev_addr_out;
  logic [15:0] ee_offset_out;
  logic [3:0] otp_cfg_num_out, otp_loaded_num_out;
  logic [1:0] port_proto_out;
  logic [7:0] img_rd_data_out;
  ee_rate_e ee_rate_out;
  img_wr_s ee_wr_in, otp_wr_in;
  enable_s enables_out;
  fail_s fail_out;
  int bad_count = 0, total_checks = 0, cycles = 0, reqs = 0, cals = 0, hfs = 0, upds = 0;
  always #2.5 clk_in = ~clk_in;
  reset_config_load_sequencer u_reset_config_load_sequencer (.*);
  far_side_model u_far_side_model (.clk_in, .rst_b_in, .ee_req_in(ee_req_out),
    .ee_dev_addr_in(ee_dev_addr_out), .ee_offset_in(ee_offset_out),
    .ee_want_update_in(ee_want_update_out), .otp_req_in(otp_req_out),
    .hotfix_run_in(hotfix_run_out), .apll_cal_in(apll_cal_out), .ack_addr_in(ack_addr),
    .blk_ok_in(blk_ok), .upd_in(upd), .otp_found_cfg_in(ofound), .otp_ok_cfg_in(ook),
    .ee_done_out(ee_done_in), .ee_ack_out(ee_ack_in), .ee_found_out(ee_found_in),
    .ee_sum_ok_out(ee_sum_ok_in), .ee_wr_out(ee_wr_in), .otp_done_out(otp_done_in),
    .otp_found_out(otp_found_in), .otp_sum_ok_out(otp_sum_ok_in), .otp_wr_out(otp_wr_in),
    .hotfix_done_out(hotfix_done_in), .apll_locked_out(apll_locked_in));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      print_verdict();
    end
    if (!rst_b_in) {reqs, cals, hfs, upds} <= '0;
    else begin
      reqs <= reqs + ee_req_out;
      cals <= cals + apll_cal_out;
      hfs <= hfs + hotfix_done_in;
      upds <= upds + update_apply_out;
    end
  end
  // GPIO held steady across release so the latch sees it
  task automatic start(input logic [3:0] g, input logic [2:0] ens, input logic [1:0] otp,
      input logic [6:0] aa, input logic [2:0] bo, input logic up);
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    gpio_pins_in <= g;
    {update_scan_en_in, ee_search_en_in, hotfix_present_in} <= ens;
    {ofound, ook, ack_addr, blk_ok, upd} <= {otp, aa, bo, up};
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1'b1;
    for (int i = 0; i < 4000 && seq_done_out !== 1'b1; i++) @(posedge clk_in);
    #1;
    check("seq_done", seq_done_out, 1'b1);
  endtask
  task automatic peek(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    img_rd_addr_in <= a;
    repeat (2) @(posedge clk_in);
    #1;
    check("image", img_rd_data_out, exp);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_otp();
    start(4'h9, 3'b001, 2'b11, 7'h00, 3'h0, 1'b0);
    check("loaded", otp_loaded_out, 1'b1);
    check("loaded_num", otp_loaded_num_out, 4'h9);
    check("proto", port_proto_out, 2'b11);
    check("cals", cals, 2);
    check("lock", apll_lock_xtal_out, 1'b1);
    check("hotfix", hfs, 1);
    check("probes", reqs, 0);
    check("enables", enables_out, 5'h1f);
    check("fail", fail_out, 5'h00);
    peek(`IMG_SER0_PROTO, 8'h01);
    peek(8'h40, 8'h00);
  endtask
  task automatic t_none();
    start(4'h3, 3'b010, 2'b00, 7'h00, 3'h0, 1'b0);
    check("loaded", otp_loaded_out, 1'b0);
    check("otp_missing", fail_out.otp_missing, 1'b1);
    check("ee_none", fail_out.ee_none, 1'b1);
    check("probes", reqs, 24);
    check("rate", ee_rate_out, RATE_100K);
    check("cals", cals, 0);
    check("hotfix", hfs, 0);
    check("proto", port_proto_out, 2'b00);
    peek(`IMG_APLL_FB, 8'h00);
  endtask
  task automatic t_ee();
    start(4'h5, 3'b010, 2'b10, 7'h52, 3'b100, 1'b0);
    check("otp_bad_sum", fail_out.otp_bad_sum, 1'b1);
    check("loaded", otp_loaded_out, 1'b0);
    check("probes", reqs, 4);
    check("ee_bad_block", fail_out.ee_bad_block, 1'b1);
    check("cals", cals, 1);
    peek(8'h30, 8'h00);
    peek(8'h31, 8'ha5);
    peek(`IMG_APLL_FB, 8'h00);
  endtask
  task automatic t_upd();
    start(4'h0, 3'b110, 2'b00, 7'h50, 3'b011, 1'b1);
    check("updates", upds, 1);
    check("ee_none", fail_out.ee_none, 1'b0);
    peek(8'h30, 8'ha5);
  endtask
  initial begin
    t_otp();
    t_none();
    t_ee();
    t_upd();
    print_verdict();
  end
endmodule
